// ==== design/comparator_sync.sv ====
// Comparator synchroniser with three-stage filter and edge pulses
`timescale 1ns/1ps

module comparator_sync
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Asynchronous comparator output
    input  wire logic cmpAsync,
    // Filtered level and edge pulses
    output logic      level,
    output logic      rise,
    output logic      fall
);

    logic stage1_r;
    logic stage2_r;
    logic stage3_r;
    logic level_r;
    logic level_nxt;
    logic rise_r;
    logic rise_nxt;
    logic fall_r;
    logic fall_nxt;

    // Level moves only once the second and third stages agree
    always_comb
    begin
        level_nxt = (stage2_r == stage3_r) ? stage3_r : level_r;
        rise_nxt  = level_nxt & ~level_r;
        fall_nxt  = ~level_nxt & level_r;
    end

    // First stage feeds only the second, so metastability stays contained
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            stage1_r <= 1'b0;
            stage2_r <= 1'b0;
            stage3_r <= 1'b0;
            level_r  <= 1'b0;
            rise_r   <= 1'b0;
            fall_r   <= 1'b0;
        end
        else
        begin
            stage1_r <= cmpAsync;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
            level_r  <= level_nxt;
            rise_r   <= rise_nxt;
            fall_r   <= fall_nxt;
        end
    end

    assign level = level_r;
    assign rise  = rise_r;
    assign fall  = fall_r;

endmodule

// ==== design/input_protect_pkg.sv ====
// Package: register map, field positions, reset values and timing for input protection
package input_protect_pkg;

    // Register byte offsets on the Avalon-MM slave
    localparam logic [4:0] UNDER_THRESHOLD_OFFSET = 5'h00;
    localparam logic [4:0] OVER_THRESHOLD_OFFSET  = 5'h04;
    localparam logic [4:0] LOCKOUT_CONTROL_OFFSET = 5'h08;
    localparam logic [4:0] OC_CONTROL_OFFSET      = 5'h0C;
    localparam logic [4:0] FLAG_OFFSET            = 5'h10;

    // Lockout control field positions
    localparam int UNDER_ENABLE_BIT  = 7;
    localparam int UNDER_STATUS_BIT  = 6;
    localparam int UNDER_RISE_BIT    = 5;
    localparam int UNDER_FALL_BIT    = 4;
    localparam int OVER_ENABLE_BIT   = 3;
    localparam int OVER_STATUS_BIT   = 2;
    localparam int OVER_RISE_BIT     = 1;
    localparam int OVER_FALL_BIT     = 0;

    // Overcurrent control field positions
    localparam int OC_ENABLE_BIT     = 7;
    localparam int OC_BLANK_LSB      = 5;
    localparam int OC_CODE_WIDTH     = 5;

    // Flag register field positions
    localparam int UNDER_FLAG_BIT    = 0;
    localparam int OVER_FLAG_BIT     = 1;
    localparam int OC_FLAG_BIT       = 2;

    // Reset values
    localparam logic [3:0] THRESHOLD_RESET      = 4'h0;
    localparam logic [7:0] LOCKOUT_CTRL_RESET   = 8'h00;
    localparam logic [7:0] OC_CTRL_RESET        = 8'h00;
    localparam logic [7:0] STATUS_RESET         = 8'h00;

    // Clock period and leading-edge blanking times
    localparam int CLK_PERIOD_NS     = 50;
    localparam int BLANK_NS_0        = 110;
    localparam int BLANK_NS_1        = 200;
    localparam int BLANK_NS_2        = 380;
    localparam int BLANK_NS_3        = 740;

    // Least times round up to whole clock cycles
    localparam logic [3:0] BLANK_CYCLES_0 = 4'((BLANK_NS_0 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] BLANK_CYCLES_1 = 4'((BLANK_NS_1 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] BLANK_CYCLES_2 = 4'((BLANK_NS_2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] BLANK_CYCLES_3 = 4'((BLANK_NS_3 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Bus handshake states
    typedef enum logic [1:0]
    {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } bus_state_t;

endpackage

// ==== design/input_voltage_and_overcurrent_protect.sv ====
// Input under/overvoltage lockout and cycle-by-cycle overcurrent limit with Avalon-MM registers
//
// Function
// - Overvoltage threshold code, 12 V up 2 V steps
// - Over threshold upper bits read zero
// - Voltage flags set regardless of lockout enables
// - Bit 6 shows undervoltage present, resets zero
// - Bit 2 shows overvoltage present, resets zero
// - Enabled undervoltage forces both gates off
// - Enabled overvoltage forces both gates off
// - Bits 7 and 3 enable lockouts, reset zero
// - Bits 5/4 pick undervoltage flag edges
// - Bits 1/0 pick overvoltage flag edges
// - Per-cycle peak current limit with flag
// - Sense only while high side conducts, after blanking
// - Overcurrent sets flag, ends high-side pulse
// - High side returns next cycle, retrips if persistent
// - Overcurrent flag clears only after clean cycle
// - Overcurrent disabled when enable bit clear
// - Overcurrent flag ignores interrupt enables
// - Undervoltage threshold code, 4 V up 2 V steps
// - Blanking select 110/200/380/740 ns
//
// Our own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps

module input_voltage_and_overcurrent_protect
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // Avalon-MM slave
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [3:0]  byteenable,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // Analog comparator results, asynchronous
    input  wire logic        underCmp,
    input  wire logic        overCmp,
    input  wire logic        overcurrentCmp,
    // PWM timebase on this clock
    input  wire logic        cycleStart,
    input  wire logic        pwmHigh,
    input  wire logic        pwmLow,
    // Threshold codes to the analog side
    output logic [3:0]       underThresholdCode,
    output logic [3:0]       overThresholdCode,
    output logic [4:0]       overcurrentThresholdCode,
    // Gate drive requests
    output logic             highSideGateOut,
    output logic             lowSideGateOut
);

    // Synchronised comparator levels and edges
    logic underLvl;
    logic underRise;
    logic underFall;
    logic overLvl;
    logic overRise;
    logic overFall;
    logic ocLvl;

    // Bus state
    input_protect_pkg::bus_state_t busState_r;
    input_protect_pkg::bus_state_t busState_nxt;
    logic        waitReq_r;
    logic        waitReq_nxt;
    logic [31:0] readData_r;
    logic [31:0] readData_nxt;
    logic        wrTake;

    // Registers
    logic [3:0]  underThr_r;
    logic [3:0]  underThr_nxt;
    logic [3:0]  overThr_r;
    logic [3:0]  overThr_nxt;
    logic [7:0]  lockCtl_r;
    logic [7:0]  lockCtl_nxt;
    logic [7:0]  ocCtl_r;
    logic [7:0]  ocCtl_nxt;
    logic        underFlag_r;
    logic        underFlag_nxt;
    logic        overFlag_r;
    logic        overFlag_nxt;
    logic        ocFlag_r;
    logic        ocFlag_nxt;

    // Overcurrent engine state
    logic [3:0]  blankCnt_r;
    logic [3:0]  blankCnt_nxt;
    logic [3:0]  blankLimit;
    logic        ocTerm_r;
    logic        ocTerm_nxt;
    logic        ocInCycle_r;
    logic        ocInCycle_nxt;
    logic        cleanCycle_r;
    logic        cleanCycle_nxt;
    logic        ocDetect;
    logic        lockout;
    logic        highGate_r;
    logic        highGate_nxt;
    logic        lowGate_r;
    logic        lowGate_nxt;

    // Comparators pass a synchroniser before any edge is seen
    comparator_sync underSync
    (
        .clk      (clk),
        .srst     (srst),
        .cmpAsync (underCmp),
        .level    (underLvl),
        .rise     (underRise),
        .fall     (underFall)
    );

    comparator_sync overSync
    (
        .clk      (clk),
        .srst     (srst),
        .cmpAsync (overCmp),
        .level    (overLvl),
        .rise     (overRise),
        .fall     (overFall)
    );

    comparator_sync ocSync
    (
        .clk      (clk),
        .srst     (srst),
        .cmpAsync (overcurrentCmp),
        .level    (ocLvl),
        .rise     (),
        .fall     ()
    );

    // Bus handshake: one wait cycle, then one cycle with waitrequest low
    always_comb
    begin
        busState_nxt = busState_r;
        waitReq_nxt  = 1'b1;
        readData_nxt = readData_r;
        case (busState_r)
            input_protect_pkg::BUS_IDLE:
            begin
                if (read || write)
                begin
                    busState_nxt = input_protect_pkg::BUS_ACK;
                    waitReq_nxt  = 1'b0;
                    readData_nxt = 32'h0000_0000;
                    case (address)
                        input_protect_pkg::UNDER_THRESHOLD_OFFSET:
                            readData_nxt[3:0] = underThr_r;
                        input_protect_pkg::OVER_THRESHOLD_OFFSET:
                            readData_nxt[3:0] = overThr_r;
                        input_protect_pkg::LOCKOUT_CONTROL_OFFSET:
                        begin
                            readData_nxt[7:0] = lockCtl_r;
                            readData_nxt[input_protect_pkg::UNDER_STATUS_BIT] = underLvl;
                            readData_nxt[input_protect_pkg::OVER_STATUS_BIT]  = overLvl;
                        end
                        input_protect_pkg::OC_CONTROL_OFFSET:
                            readData_nxt[7:0] = ocCtl_r;
                        input_protect_pkg::FLAG_OFFSET:
                        begin
                            readData_nxt[input_protect_pkg::UNDER_FLAG_BIT] = underFlag_r;
                            readData_nxt[input_protect_pkg::OVER_FLAG_BIT]  = overFlag_r;
                            readData_nxt[input_protect_pkg::OC_FLAG_BIT]    = ocFlag_r;
                        end
                        default:
                            readData_nxt = 32'h0000_0000;  // Unmapped reads as zero
                    endcase
                end
            end
            input_protect_pkg::BUS_ACK:
            begin
                busState_nxt = input_protect_pkg::BUS_IDLE;
            end
            default:
            begin
                busState_nxt = input_protect_pkg::BUS_IDLE;
            end
        endcase
    end

    // Write lands at the edge where the master sees waitrequest low
    assign wrTake = write && !waitReq_r && byteenable[0];

    // Configuration registers
    always_comb
    begin
        underThr_nxt = underThr_r;
        overThr_nxt  = overThr_r;
        lockCtl_nxt  = lockCtl_r;
        ocCtl_nxt    = ocCtl_r;
        if (wrTake)
        begin
            case (address)
                input_protect_pkg::UNDER_THRESHOLD_OFFSET:
                    underThr_nxt = writedata[3:0];
                input_protect_pkg::OVER_THRESHOLD_OFFSET:
                    overThr_nxt = writedata[3:0];
                input_protect_pkg::LOCKOUT_CONTROL_OFFSET:
                    lockCtl_nxt = writedata[7:0];
                input_protect_pkg::OC_CONTROL_OFFSET:
                    ocCtl_nxt = writedata[7:0];
                default:
                    underThr_nxt = underThr_r;  // Unmapped writes ignored
            endcase
        end
        // Status positions are read-only and never stored
        lockCtl_nxt[input_protect_pkg::UNDER_STATUS_BIT] = 1'b0;
        lockCtl_nxt[input_protect_pkg::OVER_STATUS_BIT]  = 1'b0;
    end

    // Blanking length from the two-bit selector
    always_comb
    begin
        case (ocCtl_r[input_protect_pkg::OC_BLANK_LSB +: 2])
            2'b00:   blankLimit = input_protect_pkg::BLANK_CYCLES_0;
            2'b01:   blankLimit = input_protect_pkg::BLANK_CYCLES_1;
            2'b10:   blankLimit = input_protect_pkg::BLANK_CYCLES_2;
            default: blankLimit = input_protect_pkg::BLANK_CYCLES_3;
        endcase
    end

    // Overcurrent only counts when enabled, conducting and past blanking
    assign ocDetect = ocCtl_r[input_protect_pkg::OC_ENABLE_BIT]
                      && highGate_r && (blankCnt_r >= blankLimit)
                      && ocLvl;

    // Lockout is the only path that forces both gates off
    assign lockout = (lockCtl_r[input_protect_pkg::UNDER_ENABLE_BIT] && underLvl)
                     || (lockCtl_r[input_protect_pkg::OVER_ENABLE_BIT] && overLvl);

    // Overcurrent engine and gate drive
    always_comb
    begin
        blankCnt_nxt   = blankCnt_r;
        ocTerm_nxt     = ocTerm_r;
        ocInCycle_nxt  = ocInCycle_r;
        cleanCycle_nxt = cleanCycle_r;
        // Blanking restarts with each high-side pulse
        if (!highGate_r)
            blankCnt_nxt = 4'h0;
        else if (blankCnt_r != 4'hF)
            blankCnt_nxt = blankCnt_r + 4'h1;
        if (cycleStart)
        begin
            ocTerm_nxt     = 1'b0;
            ocInCycle_nxt  = 1'b0;
            cleanCycle_nxt = !ocInCycle_r && !ocDetect;
        end
        if (ocDetect)
        begin
            ocTerm_nxt     = 1'b1;
            ocInCycle_nxt  = 1'b1;
            cleanCycle_nxt = 1'b0;
        end
        // Termination holds until the next cycle start; retrips if it persists
        highGate_nxt = pwmHigh && !lockout && !ocTerm_nxt;
        lowGate_nxt  = pwmLow && !lockout;
    end

    // Sticky flags: a set in the clearing cycle beats the clear
    always_comb
    begin
        logic clrUnder;
        logic clrOver;
        logic clrOc;
        clrUnder = wrTake && (address == input_protect_pkg::FLAG_OFFSET)
                   && writedata[input_protect_pkg::UNDER_FLAG_BIT];
        clrOver  = wrTake && (address == input_protect_pkg::FLAG_OFFSET)
                   && writedata[input_protect_pkg::OVER_FLAG_BIT];
        clrOc    = wrTake && (address == input_protect_pkg::FLAG_OFFSET)
                   && writedata[input_protect_pkg::OC_FLAG_BIT];
        // Edge selects apply; lockout enables deliberately do not
        underFlag_nxt = underFlag_r && !clrUnder;
        if ((underRise && lockCtl_r[input_protect_pkg::UNDER_RISE_BIT])
            || (underFall && lockCtl_r[input_protect_pkg::UNDER_FALL_BIT]))
            underFlag_nxt = 1'b1;
        overFlag_nxt = overFlag_r && !clrOver;
        if ((overRise && lockCtl_r[input_protect_pkg::OVER_RISE_BIT])
            || (overFall && lockCtl_r[input_protect_pkg::OVER_FALL_BIT]))
            overFlag_nxt = 1'b1;
        // Clear refused until a whole cycle has passed without a trip
        ocFlag_nxt = ocFlag_r && !(clrOc && cleanCycle_r);
        if (ocDetect)
            ocFlag_nxt = 1'b1;
    end

    // State registers
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            busState_r   <= input_protect_pkg::BUS_IDLE;
            waitReq_r    <= 1'b1;
            readData_r   <= 32'h0000_0000;
            underThr_r   <= input_protect_pkg::THRESHOLD_RESET;
            overThr_r    <= input_protect_pkg::THRESHOLD_RESET;
            lockCtl_r    <= input_protect_pkg::LOCKOUT_CTRL_RESET;
            ocCtl_r      <= input_protect_pkg::OC_CTRL_RESET;
            underFlag_r  <= 1'b0;
            overFlag_r   <= 1'b0;
            ocFlag_r     <= 1'b0;
            blankCnt_r   <= 4'h0;
            ocTerm_r     <= 1'b0;
            ocInCycle_r  <= 1'b0;
            cleanCycle_r <= 1'b0;
            highGate_r   <= 1'b0;
            lowGate_r    <= 1'b0;
        end
        else
        begin
            busState_r   <= busState_nxt;
            waitReq_r    <= waitReq_nxt;
            readData_r   <= readData_nxt;
            underThr_r   <= underThr_nxt;
            overThr_r    <= overThr_nxt;
            lockCtl_r    <= lockCtl_nxt;
            ocCtl_r      <= ocCtl_nxt;
            underFlag_r  <= underFlag_nxt;
            overFlag_r   <= overFlag_nxt;
            ocFlag_r     <= ocFlag_nxt;
            blankCnt_r   <= blankCnt_nxt;
            ocTerm_r     <= ocTerm_nxt;
            ocInCycle_r  <= ocInCycle_nxt;
            cleanCycle_r <= cleanCycle_nxt;
            highGate_r   <= highGate_nxt;
            lowGate_r    <= lowGate_nxt;
        end
    end

    // Outputs straight from flops
    assign readdata                 = readData_r;
    assign waitrequest              = waitReq_r;
    assign underThresholdCode       = underThr_r;
    assign overThresholdCode        = overThr_r;
    assign overcurrentThresholdCode = ocCtl_r[input_protect_pkg::OC_CODE_WIDTH-1:0];
    assign highSideGateOut          = highGate_r;
    assign lowSideGateOut           = lowGate_r;

endmodule

// ==== dv/input_protect_checker.sv ====
// Concurrent checks on the ports of the input protection block
`timescale 1ns/1ps

module input_protect_checker
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        srst,
    // Register bus
    input wire logic [4:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // Timebase, code and gates
    input wire logic        pwmHigh,
    input wire logic        pwmLow,
    input wire logic [3:0]  overThresholdCode,
    input wire logic        highSideGateOut,
    input wire logic        lowSideGateOut
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // A fresh request, then exactly one cycle of answer
    sequence busReq;
        (read || write) && waitrequest;
    endsequence
    sequence oneAnswer;
        !waitrequest ##1 waitrequest;
    endsequence

    AST_BUS_ANSWER:
        assert property (busReq |=> oneAnswer) else $error("bus answer not one cycle after request");
    AST_ANSWER_CAUSE:
        assert property ($fell(waitrequest) |-> $past(read || write)) else $error("answer without request");
    AST_RESET_QUIET:
        assert property ($past(srst) |-> waitrequest && readdata == 32'h0000_0000 && !highSideGateOut
                         && !lowSideGateOut) else $error("outputs not quiet after reset");
    AST_OVER_UPPER_ZERO:
        assert property (read && !waitrequest && address == input_protect_pkg::OVER_THRESHOLD_OFFSET
                         |-> readdata[31:4] == 28'h000_0000) else $error("over threshold upper bits set");
    AST_UNDER_UPPER_ZERO:
        assert property (read && !waitrequest && address == input_protect_pkg::UNDER_THRESHOLD_OFFSET
                         |-> readdata[31:4] == 28'h000_0000) else $error("under threshold upper bits set");
    AST_OVER_CODE_WRITE:
        assert property (!$stable(overThresholdCode) |-> $past(write)
                         && $past(address) == input_protect_pkg::OVER_THRESHOLD_OFFSET)
        else $error("over threshold code changed without write");
    AST_HIGH_FROM_PWM:
        assert property (highSideGateOut |-> $past(pwmHigh)) else $error("high gate without request");
    AST_LOW_FROM_PWM:
        assert property (lowSideGateOut |-> $past(pwmLow)) else $error("low gate without request");
endmodule

bind input_voltage_and_overcurrent_protect input_protect_checker chk
(
    .clk               (clk),
    .srst              (srst),
    .address           (address),
    .read              (read),
    .write             (write),
    .readdata          (readdata),
    .waitrequest       (waitrequest),
    .pwmHigh           (pwmHigh),
    .pwmLow            (pwmLow),
    .overThresholdCode (overThresholdCode),
    .highSideGateOut   (highSideGateOut),
    .lowSideGateOut    (lowSideGateOut)
);

// ==== dv/input_voltage_and_overcurrent_protect_bench.sv ====
// Self-checking bench for the input protection block
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin miscompares++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, (got), (exp)); end end

module input_voltage_and_overcurrent_protect_bench;
    logic        clk = 1'b0, srst = 1'b1, read = 1'b0, write = 1'b0, ocForce = 1'b0;
    logic [4:0]  address = 5'h00;
    logic [3:0]  byteenable = 4'h1;
    logic [31:0] writedata = 32'h0000_0000;
    logic [15:0] vinDv = 16'h0064;
    logic [31:0] readdata;
    logic        waitrequest, underCmp, overCmp, overcurrentCmp, cycleStart, pwmHigh, pwmLow;
    logic [3:0]  underThresholdCode, overThresholdCode;
    logic [4:0]  overcurrentThresholdCode;
    logic        highSideGateOut, lowSideGateOut;
    logic [7:0]  rdat;
    int          miscompares = 0, comparisons = 0, w;
    localparam logic [4:0] FLAGS = input_protect_pkg::FLAG_OFFSET;
    localparam logic [4:0] CTRL  = input_protect_pkg::LOCKOUT_CONTROL_OFFSET;
    localparam logic [4:0] OCC   = input_protect_pkg::OC_CONTROL_OFFSET;

    input_voltage_and_overcurrent_protect dut (.clk(clk), .srst(srst), .address(address), .read(read),
        .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .underCmp(underCmp), .overCmp(overCmp), .overcurrentCmp(overcurrentCmp),
        .cycleStart(cycleStart), .pwmHigh(pwmHigh), .pwmLow(pwmLow), .underThresholdCode(underThresholdCode),
        .overThresholdCode(overThresholdCode), .overcurrentThresholdCode(overcurrentThresholdCode),
        .highSideGateOut(highSideGateOut), .lowSideGateOut(lowSideGateOut));
    protect_partner far (.clk(clk), .srst(srst), .vinDv(vinDv), .ocForce(ocForce),
        .underThresholdCode(underThresholdCode), .overThresholdCode(overThresholdCode),
        .highSideGateOut(highSideGateOut), .underCmp(underCmp), .overCmp(overCmp),
        .overcurrentCmp(overcurrentCmp), .cycleStart(cycleStart), .pwmHigh(pwmHigh), .pwmLow(pwmLow));

    // 20 MHz clock
    always #25 clk = ~clk;

    // Verdict and end of run
    task automatic stop_test();
        if (miscompares == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Bounded wait step; a hang counts as a mismatch
    task automatic tick(inout int n);
        n++;
        if (n > 40)
        begin
            miscompares++;
            stop_test();
        end
        @(negedge clk);
    endtask

    // Avalon-MM access; request held until waitrequest is seen low at a rising edge
    task automatic access(input logic wr, input logic [4:0] a, input logic [7:0] wd, output logic [7:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        address   <= a;
        read      <= !wr;
        write     <= wr;
        writedata <= {24'h00_0000, wd};
        @(negedge clk);
        while (waitrequest !== 1'b0)
            tick(n);
        @(posedge clk);
        rd = readdata[7:0];
        read  <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        access(1'b1, a, d, rdat);
    endtask

    task automatic rdChk(input logic [4:0] a, input logic [7:0] exp);
        access(1'b0, a, 8'h00, rdat);
        `CHK(rdat, exp)
    endtask

    // High-side cycles counted over one whole switching period
    task automatic hiWidth(output int wd);
        int n;
        n  = 0;
        wd = 0;
        @(negedge clk);
        while (cycleStart !== 1'b1)
            tick(n);
        repeat (20)
        begin
            if (highSideGateOut === 1'b1)
                wd++;
            @(negedge clk);
        end
    endtask

    // Both gates must stay off through the whole window
    task automatic gatesOff(input int cycles);
        int bad;
        bad = 0;
        repeat (cycles)
        begin
            @(negedge clk);
            if (highSideGateOut !== 1'b0 || lowSideGateOut !== 1'b0)
                bad++;
        end
        `CHK(bad, 0)
    endtask

    // Reset values, read-zero bits, read-only status, dropped writes, unmapped space
    task automatic checkRegisters();
        rdChk(CTRL, 8'h00);
        rdChk(OCC, 8'h00);
        rdChk(FLAGS, 8'h00);
        wr(input_protect_pkg::OVER_THRESHOLD_OFFSET, 8'hFF);
        rdChk(input_protect_pkg::OVER_THRESHOLD_OFFSET, 8'h0F);
        `CHK(overThresholdCode, 4'hF)
        wr(input_protect_pkg::UNDER_THRESHOLD_OFFSET, 8'hF2);
        rdChk(input_protect_pkg::UNDER_THRESHOLD_OFFSET, 8'h02);
        `CHK(underThresholdCode, 4'h2)
        wr(CTRL, 8'hFF);
        rdChk(CTRL, 8'hBB);
        byteenable <= 4'h0;
        wr(CTRL, 8'h00);
        byteenable <= 4'h1;
        rdChk(CTRL, 8'hBB);
        wr(5'h14, 8'hFF);
        rdChk(5'h14, 8'h00);
    endtask

    // Edge selection, status, lockout of both gates
    task automatic checkVoltage();
        wr(CTRL, 8'h22);
        vinDv <= 16'h003C;
        repeat (10) @(posedge clk);
        rdChk(FLAGS, 8'h01);
        rdChk(CTRL, 8'h62);
        hiWidth(w);
        `CHK(w, 10)
        wr(FLAGS, 8'h01);
        vinDv <= 16'h0064;
        repeat (10) @(posedge clk);
        rdChk(FLAGS, 8'h00);
        wr(CTRL, 8'h99);
        vinDv <= 16'h01C2;
        repeat (10) @(posedge clk);
        rdChk(CTRL, 8'h9D);
        gatesOff(45);
        rdChk(FLAGS, 8'h00);
        vinDv <= 16'h0064;
        repeat (10) @(posedge clk);
        rdChk(FLAGS, 8'h02);
        vinDv <= 16'h003C;
        repeat (10) @(posedge clk);
        gatesOff(45);
        vinDv <= 16'h0064;
        repeat (10) @(posedge clk);
        rdChk(FLAGS, 8'h03);
        wr(CTRL, 8'h00);
        wr(FLAGS, 8'h03);
    endtask

    // Cycle-by-cycle limit, blanking, refused and accepted clear, disable
    task automatic checkOvercurrent();
        wr(OCC, 8'h83);
        rdChk(OCC, 8'h83);
        `CHK(overcurrentThresholdCode, 5'h03)
        ocForce <= 1'b1;
        hiWidth(w);
        `CHK(w > 0 && w < 10, 1'b1)
        hiWidth(w);
        `CHK(w > 0 && w < 10, 1'b1)
        rdChk(FLAGS, 8'h04);
        wr(FLAGS, 8'h04);
        rdChk(FLAGS, 8'h04);
        ocForce <= 1'b0;
        hiWidth(w);
        `CHK(w, 10)
        repeat (40) @(posedge clk);
        wr(FLAGS, 8'h04);
        rdChk(FLAGS, 8'h00);
        wr(OCC, 8'hE0);
        ocForce <= 1'b1;
        hiWidth(w);
        `CHK(w, 10)
        wr(OCC, 8'h00);
        hiWidth(w);
        `CHK(w, 10)
        rdChk(FLAGS, 8'h00);
        ocForce <= 1'b0;
    endtask

    // Main sequence
    initial
    begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        checkRegisters();
        checkVoltage();
        checkOvercurrent();
        stop_test();
    end

    // Overall guard against a hang
    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        stop_test();
    end
endmodule

// ==== dv/protect_partner.sv ====
// Far-side model: input voltage comparators, overcurrent sense and switching timebase
`timescale 1ns/1ps

module protect_partner
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // Bench controls: input voltage in tenths of a volt, forced overcurrent
    input  wire logic [15:0] vinDv,
    input  wire logic        ocForce,
    // Codes and gate from the block
    input  wire logic [3:0]  underThresholdCode,
    input  wire logic [3:0]  overThresholdCode,
    input  wire logic        highSideGateOut,
    // Comparator results and timebase
    output logic             underCmp,
    output logic             overCmp,
    output logic             overcurrentCmp,
    output logic             cycleStart,
    output logic             pwmHigh,
    output logic             pwmLow
);
    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;

    // Trip points: under from 4.0 V, over from 12.0 V, both 2.0 V a step
    assign underCmp = vinDv < 16'h0028 + 16'h0014 * {12'h000, underThresholdCode};
    assign overCmp  = vinDv > 16'h0078 + 16'h0014 * {12'h000, overThresholdCode};
    // Drop is only sensed while the high-side switch conducts
    assign overcurrentCmp = ocForce & highSideGateOut;

    // Twenty-cycle period keeps runs short; dead time around the low pulse
    always_comb
    begin
        cnt_nxt = (srst || cnt_r == 5'h13) ? 5'h00 : cnt_r + 5'h01;
    end
    always_ff @(posedge clk)
    begin
        cnt_r <= cnt_nxt;
    end
    assign cycleStart = cnt_r == 5'h00;
    assign pwmHigh    = cnt_r < 5'h0A;
    assign pwmLow     = cnt_r >= 5'h0B && cnt_r < 5'h13;
endmodule
